// ### psr_host.sv
/*
 * Host controller model that issues register accesses on the serial
 * register port decoder side of the register bank.
 * Assumes one-cycle read and write strobes sampled on the rising mclk edge.
 */
`timescale 1ns/10ps
module psr_host
    import psr_pkg::*;
(
    input  wire logic                       mclk,
    output logic                            reg_wr,
    output logic                            reg_rd,
    output logic [psr_pkg::ADDR_W-1:0]      reg_addr,
    output logic [psr_pkg::DATA_W-1:0]      reg_wdata,
    input  wire logic [psr_pkg::DATA_W-1:0] reg_rdata,
    input  wire logic                       reg_rvalid
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h2a;
        reg_wdata = 24'h5a5a5a;
    end

    function automatic logic [DATA_W-1:0] fill(logic [ADDR_W-1:0] a,
                                               logic [DATA_W-1:0] d);
        case (a)
            ADDR_AUX: return (d & MASK_AUX) | (RST_AUX & ~MASK_AUX);
            ADDR_OSC: return (d & MASK_OSC) | (RST_OSC & ~MASK_OSC);
            ADDR_DIV: return (d & MASK_DIV) | (RST_DIV & ~MASK_DIV);
            default:  return d;
        endcase
    endfunction

    // A raw access skips the reserved-field fill so that a scenario can
    // deliberately write ones into reserved bits.
    task automatic access(input logic wr, input logic rd, input logic raw,
                          input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input int gap,
                          output logic [DATA_W-1:0] q, output logic v);
        repeat (gap) @(negedge mclk);
        @(negedge mclk);
        reg_wr = wr;
        reg_rd = rd;
        reg_addr = a;
        reg_wdata = raw ? d : fill(a, d);
        @(negedge mclk);
        q = reg_rdata;
        v = reg_rvalid;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        // Released lines show the inverse so stale values are never reused.
        reg_addr = ~reg_addr;
        reg_wdata = ~reg_wdata;
    endtask
endmodule

// ### psr_pkg.sv
/*
 * Constants for the synthesizer status, auxiliary port, oscillator and
 * divider register bank: register addresses, field positions, write masks
 * and reset values.
 * Assumes a 6-bit register address and 24-bit register words from the
 * serial register port decoder.
 */
package psr_pkg;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 24;
    localparam int SRC_W  = 32;

    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_CAL  = 6'h11;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 6'h12;
    localparam logic [ADDR_W-1:0] ADDR_SELF = 6'h13;
    localparam logic [ADDR_W-1:0] ADDR_AUX  = 6'h14;
    localparam logic [ADDR_W-1:0] ADDR_OSC  = 6'h15;
    localparam logic [ADDR_W-1:0] ADDR_DIV  = 6'h16;

    // Reset values and writable-bit masks.
    localparam logic [DATA_W-1:0] RST_CAL   = 24'h07ffff;
    localparam logic [DATA_W-1:0] RST_STAT  = 24'h00001c;
    localparam logic [DATA_W-1:0] RST_SELF  = 24'h001259;
    localparam logic [DATA_W-1:0] RST_AUX   = 24'h000220;
    localparam logic [DATA_W-1:0] MASK_AUX  = 24'h003e1f;
    localparam logic [DATA_W-1:0] RST_OSC   = 24'h0f48a0;
    localparam logic [DATA_W-1:0] MASK_OSC  = 24'h0103ff;
    localparam logic [DATA_W-1:0] RST_DIV   = 24'h0006c1;
    localparam logic [DATA_W-1:0] MASK_DIV  = 24'h0007ff;
    localparam logic [DATA_W-1:0] RD_ZERO   = 24'h000000;

    // Calibration error layout.
    localparam int CAL_W = 20;
    localparam int CAL_SIGN = 19;

    // Status register bits.
    localparam int STAT_GEN  = 0;
    localparam int STAT_LOCK = 1;

    // Auxiliary port control fields.
    localparam int AUX_MODE    = 0;
    localparam int AUX_VAL_LO  = 1;
    localparam int AUX_VAL_HI  = 3;
    localparam int AUX_LVL     = 4;
    localparam int AUX_PSYNC   = 9;
    localparam int AUX_ROUTE_LO = 10;
    localparam int AUX_ROUTE_HI = 11;
    localparam int AUX_IDLE_LO = 12;
    localparam int AUX_IDLE_HI = 13;
    localparam int AUX_PINS    = 3;

    typedef enum logic [1:0] {
        PSR_IDLE_HIZ  = 2'h0,
        PSR_IDLE_KEEP = 2'h1,
        PSR_IDLE_HIGH = 2'h2,
        PSR_IDLE_LOW  = 2'h3
    } psr_idle_t;

    // Manual oscillator fields.
    localparam int OSC_MCAL     = 0;
    localparam int OSC_CAP_LO   = 1;
    localparam int OSC_CAP_HI   = 5;
    localparam int OSC_BAND_LO  = 6;
    localparam int OSC_BAND_HI  = 8;
    localparam int OSC_MTUNE    = 9;
    localparam int OSC_AUTOSCL  = 16;

    // Divider and gain fields.
    localparam int DIV_CODE_LO  = 0;
    localparam int DIV_CODE_HI  = 5;
    localparam int DIV_G1_LO    = 6;
    localparam int DIV_G1_HI    = 7;
    localparam int DIV_G2_LO    = 8;
    localparam int DIV_G2_HI    = 9;
    localparam int DIV_STAGE    = 10;
    localparam logic [5:0] DIV_MUTE    = 6'h00;
    localparam logic [5:0] DIV_MIN_ODD = 6'h03;
    localparam logic [5:0] DIV_MAX     = 6'h3e;
endpackage

// ### psr_regs.sv
/*
 * Register bank for calibration error, status, self-test, auxiliary
 * three-pin port, manual oscillator setup and output divider gain.
 * Assumes the serial register port decoder hands over one-cycle read and
 * write strobes with address and data on mclk; analog status inputs and
 * the chip-enable pin are asynchronous and are synchronised here.
 */
// What this block does
// [RULE_01] Read-only signed 19-bit calibration error, magnitude resets to all ones; the code holds a 20-bit field with the sign at bit 19.
// [RULE_02] Status bit 0 mirrors general output, bit 1 lock detect, zero at reset.
// [RULE_03] Mode bit one runs aux pins as serial port, zero as static levels.
// [RULE_04] Static mode drives each aux pin from value field bits 3:1.
// [RULE_05] Bit 4 picks 1.8 V or 3.3 V aux signalling level.
// [RULE_06] Phase-sync bit makes chip-enable a sync trigger; needs exact frequency mode.
// [RULE_07] Bits 11:10 route the general output to no pin or pin 0, 1, 2.
// [RULE_08] With serial port off, bits 13:12 pick hi-Z, keep, high or low.
// [RULE_09] Bit 0 of oscillator register enables manual calibration, off at reset.
// [RULE_10] Capacitor setting bits 5:1 reset 16, sub-band bits 8:6 reset 2.
// [RULE_11] Manual tuning applies only while bit 9 is one.
// [RULE_12] Bit 16 enables automatic pump current scaling, set at reset.
// [RULE_13] Divide code 0 mutes, 1 passes through, even codes divide.
// [RULE_14] Odd codes fall to next lower even, codes above 62 act as 62.
// [RULE_15] Two 2-bit buffer gain fields: 3 max, then 3, 6, 9 dB lower.
// [RULE_16] Bit 10 sets divider stage to max gain, else 3 dB below.
// [RULE_17] A 5-bit select picks the signal for the general output multiplexer.
// [RULE_18] Writes to read-only registers ignored; reserved fields read reset values.
// [RULE_19] Host writes reserved fields with their reset values.
`timescale 1ns/10ps
module psr_regs
    import psr_pkg::*;
(
    input  wire logic                        mclk,
    input  wire logic                        srst,
    input  wire logic                        reg_wr,
    input  wire logic                        reg_rd,
    input  wire logic [psr_pkg::ADDR_W-1:0]  reg_addr,
    input  wire logic [psr_pkg::DATA_W-1:0]  reg_wdata,
    output logic      [psr_pkg::DATA_W-1:0]  reg_rdata,
    output logic                             reg_rvalid,
    input  wire logic [psr_pkg::CAL_W-1:0]   cal_search_in,
    input  wire logic                        lock_detect_in,
    input  wire logic [psr_pkg::SRC_W-1:0]   general_output_src,
    input  wire logic [4:0]                  general_output_sel,
    input  wire logic                        chip_en_pin,
    input  wire logic                        exact_freq_mode,
    input  wire logic [psr_pkg::AUX_PINS-1:0] aux_serial_out,
    output logic      [psr_pkg::AUX_PINS-1:0] aux_out,
    output logic      [psr_pkg::AUX_PINS-1:0] aux_oe,
    output logic                             aux_level_select,
    output logic                             phase_sync_trigger,
    output logic                             manual_cal_en,
    output logic      [4:0]                  cap_switch,
    output logic      [2:0]                  osc_subband,
    output logic                             manual_tune_en,
    output logic                             pump_current_autoscale,
    output logic      [5:0]                  output_divide_ratio,
    output logic                             output_mute,
    output logic      [1:0]                  first_osc_output_gain,
    output logic      [1:0]                  second_osc_output_gain,
    output logic                             divider_stage_max_gain
);
    import psr_pkg::*;

    // Synchroniser stages; stage one is read only by stage two.
    logic [CAL_W-1:0] cal_s1, cal_s2;
    logic [SRC_W-1:0] src_s1, src_s2;
    logic             lock_s1, lock_s2, ce_s1, ce_s2, ce_d;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cal_s1  <= RST_CAL[CAL_W-1:0];
            cal_s2  <= RST_CAL[CAL_W-1:0];
            src_s1  <= '0;
            src_s2  <= '0;
            lock_s1 <= 1'b0;
            lock_s2 <= 1'b0;
            ce_s1   <= 1'b0;
            ce_s2   <= 1'b0;
            ce_d    <= 1'b0;
        end else begin
            cal_s1  <= cal_search_in;
            cal_s2  <= cal_s1;
            src_s1  <= general_output_src;
            src_s2  <= src_s1;
            lock_s1 <= lock_detect_in;
            lock_s2 <= lock_s1;
            ce_s1   <= chip_en_pin;
            ce_s2   <= ce_s1;
            ce_d    <= ce_s2;
        end
    end

    logic [DATA_W-1:0] aux_reg, osc_reg, div_reg, stat_reg, cal_reg;
    logic [DATA_W-1:0] next_aux, next_osc, next_div, next_stat, next_cal;
    logic [DATA_W-1:0] next_rdata;
    logic              next_rvalid, gen_mux;

    // The general output is a plain mux; the select comes from a
    // neighbouring register on the same clock, so it needs no sync.
    assign gen_mux = src_s2[general_output_sel]; // RULE_17

    // Writable registers keep reserved bits at reset value whatever the
    // host writes, so a careless write cannot disturb analog trim bits.
    always_comb begin
        next_aux = aux_reg;
        next_osc = osc_reg;
        next_div = div_reg;
        if (reg_wr) begin
            unique case (reg_addr)
                ADDR_AUX: next_aux = (reg_wdata & MASK_AUX)
                                   | (RST_AUX & ~MASK_AUX); // RULE_18
                ADDR_OSC: next_osc = (reg_wdata & MASK_OSC)
                                   | (RST_OSC & ~MASK_OSC); // RULE_18
                ADDR_DIV: next_div = (reg_wdata & MASK_DIV)
                                   | (RST_DIV & ~MASK_DIV); // RULE_18
                default: ;
            endcase
        end
        next_cal = RST_CAL & ~RST_CAL;
        next_cal[CAL_W-1:0] = cal_s2; // RULE_01
        next_stat = RST_STAT;
        next_stat[STAT_GEN]  = gen_mux; // RULE_02
        next_stat[STAT_LOCK] = lock_s2; // RULE_02
    end

    always_comb begin
        next_rvalid = reg_rd;
        next_rdata  = RD_ZERO;
        if (reg_rd) begin
            unique case (reg_addr)
                ADDR_CAL:  next_rdata = cal_reg;
                ADDR_STAT: next_rdata = stat_reg;
                ADDR_SELF: next_rdata = RST_SELF; // RULE_18
                ADDR_AUX:  next_rdata = aux_reg;
                ADDR_OSC:  next_rdata = osc_reg;
                ADDR_DIV:  next_rdata = div_reg;
                default:   next_rdata = RD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            aux_reg    <= RST_AUX;
            osc_reg    <= RST_OSC;
            div_reg    <= RST_DIV;
            cal_reg    <= RST_CAL;
            // Reserved status bits must read their fixed value from reset on.
            stat_reg   <= RST_STAT;
            reg_rdata  <= RD_ZERO;
            reg_rvalid <= 1'b0;
        end else begin
            aux_reg    <= next_aux;
            osc_reg    <= next_osc;
            div_reg    <= next_div;
            cal_reg    <= next_cal;
            stat_reg   <= next_stat;
            reg_rdata  <= next_rdata;
            reg_rvalid <= next_rvalid;
        end
    end

    // Auxiliary pin drive.
    logic [AUX_PINS-1:0] next_aux_out, next_aux_oe;
    logic                next_trig;
    logic [5:0]          code, next_ratio;
    psr_idle_t           idle;
    logic [1:0]          route;

    assign idle  = psr_idle_t'(aux_reg[AUX_IDLE_HI:AUX_IDLE_LO]);
    assign route = aux_reg[AUX_ROUTE_HI:AUX_ROUTE_LO];
    assign code  = div_reg[DIV_CODE_HI:DIV_CODE_LO];

    always_comb begin
        if (aux_reg[AUX_MODE]) begin
            next_aux_out = aux_serial_out; // RULE_03
            next_aux_oe  = '1;
        end else begin
            next_aux_out = aux_reg[AUX_VAL_HI:AUX_VAL_LO]; // RULE_04
            next_aux_oe  = '1;
            unique case (idle) // RULE_08
                PSR_IDLE_HIZ:  next_aux_oe  = '0;
                PSR_IDLE_KEEP: next_aux_oe  = '1;
                PSR_IDLE_HIGH: next_aux_out = '1;
                PSR_IDLE_LOW:  next_aux_out = '0;
            endcase
        end
        // Routing overrides only the value; the drive state still follows
        // the mode, so a hi-Z idle port never starts driving by itself.
        for (int i = 0; i < AUX_PINS; i++) begin
            if (route == 2'(i + 1)) begin
                next_aux_out[i] = gen_mux; // RULE_07
            end
        end
        // Triggering without exact frequency mode would step the phase
        // unpredictably, so the trigger is held off until it is on.
        next_trig = aux_reg[AUX_PSYNC] && exact_freq_mode
                  && ce_s2 && !ce_d; // RULE_06
        // Odd codes from 3 up drop their low bit; codes above the top clamp to it.
        if (code > DIV_MAX) begin
            next_ratio = DIV_MAX; // RULE_14
        end else if (code >= DIV_MIN_ODD) begin
            next_ratio = {code[5:1], 1'b0}; // RULE_14
        end else begin
            next_ratio = code; // RULE_13
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            aux_out                <= '0;
            aux_oe                 <= '0;
            aux_level_select       <= RST_AUX[AUX_LVL];
            phase_sync_trigger     <= 1'b0;
            manual_cal_en          <= RST_OSC[OSC_MCAL];
            cap_switch             <= RST_OSC[OSC_CAP_HI:OSC_CAP_LO];
            osc_subband            <= RST_OSC[OSC_BAND_HI:OSC_BAND_LO];
            manual_tune_en         <= RST_OSC[OSC_MTUNE];
            pump_current_autoscale <= RST_OSC[OSC_AUTOSCL];
            output_divide_ratio    <= RST_DIV[DIV_CODE_HI:DIV_CODE_LO];
            output_mute            <= 1'b0;
            first_osc_output_gain  <= RST_DIV[DIV_G1_HI:DIV_G1_LO];
            second_osc_output_gain <= RST_DIV[DIV_G2_HI:DIV_G2_LO];
            divider_stage_max_gain <= RST_DIV[DIV_STAGE];
        end else begin
            aux_out                <= next_aux_out;
            aux_oe                 <= next_aux_oe;
            aux_level_select       <= aux_reg[AUX_LVL]; // RULE_05
            phase_sync_trigger     <= next_trig;
            manual_cal_en          <= osc_reg[OSC_MCAL]; // RULE_09
            cap_switch             <= osc_reg[OSC_CAP_HI:OSC_CAP_LO]; // RULE_10
            osc_subband            <= osc_reg[OSC_BAND_HI:OSC_BAND_LO]; // RULE_10
            manual_tune_en         <= osc_reg[OSC_MTUNE]; // RULE_11
            pump_current_autoscale <= osc_reg[OSC_AUTOSCL]; // RULE_12
            output_divide_ratio    <= next_ratio;
            output_mute            <= (code == DIV_MUTE); // RULE_13
            first_osc_output_gain  <= div_reg[DIV_G1_HI:DIV_G1_LO]; // RULE_15
            second_osc_output_gain <= div_reg[DIV_G2_HI:DIV_G2_LO]; // RULE_15
            divider_stage_max_gain <= div_reg[DIV_STAGE]; // RULE_16
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    sequence s_ce_rise;
        !ce_d && ce_s2;
    endsequence
    sequence s_write_div;
        reg_wr && reg_addr == ADDR_DIV;
    endsequence

    a_unmapped_read: assert property ( // RULE_18
        reg_rd && !(reg_addr inside {[ADDR_CAL:ADDR_DIV]})
        |=> reg_rvalid && reg_rdata == RD_ZERO)
        else $error("unmapped read did not return zero");
    a_selftest_read: assert property ( // RULE_18
        reg_rd && reg_addr == ADDR_SELF |=> reg_rdata == RST_SELF)
        else $error("self-test register read wrong value");
    a_sign_path: assert property ( // RULE_01
        reg_rd && reg_addr == ADDR_CAL
        |=> reg_rdata[CAL_SIGN] == $past(cal_s2[CAL_SIGN], 2))
        else $error("calibration sign not reported");
    a_lock_status: assert property ( // RULE_02
        reg_rd && reg_addr == ADDR_STAT
        |=> reg_rdata[STAT_LOCK] == $past(lock_s2, 2))
        else $error("lock status bit wrong");
    a_phase_trigger: assert property ( // RULE_06
        s_ce_rise ##0 (aux_reg[AUX_PSYNC] && exact_freq_mode)
        |=> phase_sync_trigger ##1 !phase_sync_trigger)
        else $error("phase sync trigger not a single pulse");
    a_no_trigger: assert property ( // RULE_06
        !exact_freq_mode |=> !phase_sync_trigger)
        else $error("trigger without exact frequency mode");
    a_idle_hiz: assert property ( // RULE_08
        !aux_reg[AUX_MODE] && idle == PSR_IDLE_HIZ |=> aux_oe == '0)
        else $error("aux pins driven in hi-Z idle");
    a_idle_low: assert property ( // RULE_08
        !aux_reg[AUX_MODE] && idle == PSR_IDLE_LOW && route == 2'h0
        |=> aux_out == '0 && aux_oe == '1)
        else $error("aux pins not forced low");
    a_route_pin: assert property ( // RULE_07
        route == 2'h2 |=> aux_out[1] == $past(gen_mux))
        else $error("general output not routed to pin 1");
    a_div_clamp: assert property ( // RULE_14
        s_write_div ##1 (code > DIV_MAX) |=> output_divide_ratio == DIV_MAX)
        else $error("divide code above top not clamped");
    a_div_odd: assert property ( // RULE_14
        code >= DIV_MIN_ODD && code <= DIV_MAX && code[0]
        |=> output_divide_ratio == $past(code) - 6'h01)
        else $error("odd divide code not lowered");
    a_div_mute: assert property ( // RULE_13
        code == DIV_MUTE |=> output_mute && output_divide_ratio == DIV_MUTE)
        else $error("divide code zero did not mute");
    a_read_valid: assert property ( // RULE_18
        reg_rd |=> reg_rvalid)
        else $error("read strobe not answered");
    a_idle_rdata: assert property ( // RULE_18
        !reg_rd |=> !reg_rvalid && reg_rdata == RD_ZERO)
        else $error("read data not cleared between reads");
    a_stat_reserved: assert property ( // RULE_18
        reg_rd && reg_addr == ADDR_STAT
        |=> reg_rdata[DATA_W-1:STAT_LOCK+1] == RST_STAT[DATA_W-1:STAT_LOCK+1])
        else $error("status reserved bits wrong");
endmodule

// ### tb_top.sv
/*
 * Self-checking testbench for the register bank: reset values, read-only
 * and reserved fields, divider fallback, oscillator fields, auxiliary pins,
 * status mirroring and the phase-sync trigger.
 * Assumes psr_regs and the psr_host model are compiled before it.
 */
`timescale 1ns/10ps
module tb_top;
    import psr_pkg::*;
    logic        mclk = 1'b0;
    logic        srst = 1'b1;
    logic        reg_wr, reg_rd, reg_rvalid;
    logic [5:0]  reg_addr;
    logic [23:0] reg_wdata, reg_rdata;
    logic [19:0] cal_in = 20'h7ffff;
    logic        lock_in = 1'b0;
    logic [31:0] gsrc = 32'h00000000;
    logic [4:0]  gsel = 5'h01;
    logic        ce_pin = 1'b0;
    logic        exact = 1'b0;
    logic [2:0]  ser = 3'h0;
    logic [2:0]  aux_out, aux_oe, band;
    logic [4:0]  cap;
    logic [5:0]  ratio;
    logic [1:0]  g1, g2;
    logic        lvl, trig, mcal, mtune, autos, mute, stg;
    logic [31:0] seed = 32'h0000b7a6;
    logic [31:0] r;
    int          num_errors = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          n;

    always #2.5 mclk = ~mclk;

    psr_host host_inst (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid));

    psr_regs psr_regs_inst (.mclk(mclk), .srst(srst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .cal_search_in(cal_in), .lock_detect_in(lock_in),
        .general_output_src(gsrc), .general_output_sel(gsel),
        .chip_en_pin(ce_pin), .exact_freq_mode(exact),
        .aux_serial_out(ser), .aux_out(aux_out), .aux_oe(aux_oe),
        .aux_level_select(lvl), .phase_sync_trigger(trig),
        .manual_cal_en(mcal), .cap_switch(cap), .osc_subband(band),
        .manual_tune_en(mtune), .pump_current_autoscale(autos),
        .output_divide_ratio(ratio), .output_mute(mute),
        .first_osc_output_gain(g1), .second_osc_output_gain(g2),
        .divider_stage_max_gain(stg));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [5:0] exp_aux(logic [23:0] v, logic gen,
                                           logic [2:0] s);
        logic [2:0] o;
        logic [2:0] e;
        o = s;
        e = 3'h7;
        if (!v[0]) begin
            o = v[3:1];
            if (v[13:12] == 2'h0) e = 3'h0;
            if (v[13:12] == 2'h2) o = 3'h7;
            if (v[13:12] == 2'h3) o = 3'h0;
        end
        if (v[11:10] != 2'h0) o[v[11:10] - 2'h1] = gen;
        return {e, o & e};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask

    task automatic wr(input logic [5:0] a, input logic [23:0] d,
                      input logic raw);
        logic [23:0] q;
        logic        v;
        host_inst.access(1'b1, 1'b0, raw, a, d, rnd() % 3, q, v);
        repeat (2) @(negedge mclk);
    endtask

    task automatic rd(input logic [5:0] a, input logic [23:0] want);
        logic [23:0] q;
        logic        v;
        host_inst.access(1'b0, 1'b1, 1'b0, a, 24'h000000, rnd() % 3, q, v);
        check(v, 1);
        check(q, want);
        @(negedge mclk);
        check({reg_rvalid, reg_rdata}, 25'h0);
    endtask

    task automatic summarize();
        if (num_errors == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 8000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        logic [23:0] q;
        logic        v;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check({mcal, cap, band, mtune, autos, ratio, mute, g1, g2, stg, lvl,
               aux_oe, trig}, {1'h0, 5'h10, 3'h2, 1'h0, 1'h1, 6'h01, 1'h0,
               2'h3, 2'h2, 1'h1, 1'h0, 3'h0, 1'h0});
        rd(ADDR_CAL, 24'h07ffff);
        rd(ADDR_STAT, 24'h00001c);
        rd(ADDR_SELF, 24'h001259);
        rd(ADDR_AUX, 24'h000220);
        rd(ADDR_OSC, 24'h0f48a0);
        rd(ADDR_DIV, 24'h0006c1);
        for (int i = 0; i < 3; i++)
            wr(ADDR_CAL + 6'(i), 24'hffffff, 1'b1);
        rd(ADDR_CAL, 24'h07ffff);
        rd(ADDR_STAT, 24'h00001c);
        rd(ADDR_SELF, 24'h001259);
        wr(ADDR_AUX, 24'hffffff, 1'b1);
        wr(ADDR_OSC, 24'hffffff, 1'b1);
        wr(ADDR_DIV, 24'hffffff, 1'b1);
        rd(ADDR_AUX, MASK_AUX | (RST_AUX & ~MASK_AUX));
        rd(ADDR_OSC, MASK_OSC | (RST_OSC & ~MASK_OSC));
        host_inst.access(1'b1, 1'b1, 1'b0, ADDR_DIV, 24'h00003f, 0, q, v);
        check({v, q}, {1'b1, 24'h0007ff});
        rd(ADDR_DIV, 24'h00003f);
        rd(6'h00, 24'h000000);
        for (int c = 0; c < 64; c++) begin
            r = rnd();
            wr(ADDR_DIV, {13'h0, r[10:6], 6'(c)}, 1'b0);
            check({mute, g1, g2, stg}, {c == 0, r[7:6], r[9:8], r[10]});
            check(ratio, (c < 2) ? c : ((c > 62) ? 62 : (c & 62)));
        end
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            wr(ADDR_OSC, r[23:0], 1'b0);
            check({mcal, cap, band, mtune, autos},
                  {r[0], r[5:1], r[8:6], r[9], r[16]});
        end
        for (int i = 0; i < 40; i++) begin
            r = rnd() & 32'h00003dff;
            gsrc = rnd();
            gsel = 5'(rnd());
            ser = 3'(rnd());
            lock_in = seed[7];
            cal_in = 20'(rnd());
            wr(ADDR_AUX, r[23:0], 1'b0);
            repeat (4) @(negedge mclk);
            check({aux_oe, aux_out & aux_oe},
                  exp_aux(r[23:0], gsrc[gsel], ser));
            check(lvl, r[4]);
            rd(ADDR_STAT, {22'h7, lock_in, gsrc[gsel]});
            rd(ADDR_CAL, {4'h0, cal_in});
        end
        for (int k = 0; k < 3; k++) begin
            wr(ADDR_AUX, (k == 2) ? 24'h000000 : 24'h000200, 1'b0);
            exact = (k != 1);
            repeat (3) @(negedge mclk);
            ce_pin = 1'b1;
            n = 0;
            repeat (8) @(negedge mclk) if (trig !== 1'b0) n++;
            ce_pin = 1'b0;
            repeat (4) @(negedge mclk);
            check(n, (k == 0) ? 1 : 0);
        end
        // A reset in mid-run must bring back every reset value.
        srst = 1'b1;
        repeat (8) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        check({aux_out, aux_oe, trig, ratio, mute, lvl},
              {3'h0, 3'h0, 1'h0, 6'h01, 1'h0, 1'h0});
        rd(ADDR_AUX, RST_AUX);
        rd(ADDR_OSC, RST_OSC);
        rd(ADDR_DIV, RST_DIV);
        summarize();
    end
endmodule
